// [hw/spi_cfg_map.vh]
// Register map and field positions for the SPI option and bit-rate block.
// Included by the design file; definitions only.
`ifndef SPI_CFG_MAP_VH
`define SPI_CFG_MAP_VH

// Byte offsets on the Avalon-MM slave
`define OFS_OPTION   6'h00
`define OFS_BITRATE  6'h04
`define OFS_MODE     6'h08
`define OFS_STATUS   6'h0c
`define OFS_MATCH    6'h10
`define OFS_RXDATA   6'h14

// Option control fields
`define OPT_MIE      7
`define OPT_WIDE     6
`define OPT_FDE      4
`define OPT_SWDE     3
`define OPT_HALT     1
`define OPT_SWS      0
`define OPT_MASK     8'hdb

// Bit-rate fields
`define BR_PRE_HI    6
`define BR_PRE_LO    4
`define BR_RATE_HI   2
`define BR_RATE_LO   0
`define BR_MASK      8'h77

// Mode register fields
`define MODE_EN      0
`define MODE_MSTR    1
`define MODE_SELECT_OUTPUT_ENABLE    2

// Status fields
`define ST_FULL      7
`define ST_MATCH     6
`define ST_FAULT     4

// Reset values
`define OPT_RST      8'h00
`define BR_RST       8'h00
`define MODE_RST     8'h00
`define MATCH_RST    16'h0000

`endif

// [hw/spi_ctrl2_and_baud_gen.v]
// Option control, bit-rate generator, pin steering and receive FIFO of an SPI unit.
// Assumes a shifter outside that uses the pin steering, baud strobes and rx stream.
`timescale 1ns/1ns
`include "spi_cfg_map.vh"

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module spi_rx_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire flush,
  // Fill side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Full and empty come straight from the count
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  // Storage has no reset; only pointers and count need a defined state
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap by power-of-two depth
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ----------------------------------------
// Top: option control and bit-rate generator
// ----------------------------------------
module spi_ctrl2_and_baud_gen #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Avalon-MM slave
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // System state
  input wire wait_state,
  // Receive stream from the shifter
  input wire [15:0] rx_word,
  input wire rx_valid,
  output wire rx_ready,
  // Shifter control
  output wire word_16,
  output reg abort_pulse,
  output reg baud_edge,
  output wire shared_mode,
  output wire data_in_bit,
  input wire tx_bit,
  input wire ss_assert,
  // Interrupt request
  output wire match_irq,
  // Pins
  output reg sck_o,
  output wire sck_oe,
  input wire mosi_i,
  output wire mosi_o,
  output wire mosi_oe,
  input wire miso_i,
  output wire miso_o,
  output wire miso_oe,
  input wire ss_n_i,
  output wire ss_n_o,
  output wire ss_n_oe,
  output wire ss_n_to_slave,
  output wire ss_gpio_release,
  output wire mosi_gpio_release,
  output wire miso_gpio_release
);
  reg [7:0] option_reg;
  reg [7:0] bitrate_reg;
  reg [7:0] mode_reg;
  reg [15:0] match_reg;
  reg ack_reg;
  reg rx_match_flag_reg;
  reg mode_fault_flag_reg;
  reg [2:0] pre_cnt_reg;
  reg [7:0] rate_cnt_reg;
  reg [31:0] read_next;
  wire wr_go, rd_go, spi_en, master, sel_out_en, fault_en, single_wire, drive_en;
  wire pre_tick, clocks_run, width_change, rx_full_flag, fifo_pop, push_now, fault_input;
  wire [2:0] pre_sel, rate_sel;
  wire [7:0] half_count;
  wire [15:0] word_mask, head_word;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state per access so read data can come from a flop
  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_go = write & ack_reg;
  assign rd_go = read & ack_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign spi_en = mode_reg[`MODE_EN];
  assign master = mode_reg[`MODE_MSTR];
  assign sel_out_en = mode_reg[`MODE_SELECT_OUTPUT_ENABLE];
  assign fault_en = option_reg[`OPT_FDE];
  assign single_wire = option_reg[`OPT_SWS];
  assign drive_en = option_reg[`OPT_SWDE];
  assign pre_sel = bitrate_reg[`BR_PRE_HI:`BR_PRE_LO];
  assign rate_sel = bitrate_reg[`BR_RATE_HI:`BR_RATE_LO];
  assign word_16 = option_reg[`OPT_WIDE];
  assign word_mask = word_16 ? 16'hffff : 16'h00ff;
  assign width_change = wr_go & (address == `OFS_OPTION) &
    (writedata[`OPT_WIDE] != option_reg[`OPT_WIDE]) & master;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Bit-rate writes only store; counters are not disturbed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      option_reg <= `OPT_RST;
      bitrate_reg <= `BR_RST;
      mode_reg <= `MODE_RST;
      match_reg <= `MATCH_RST;
    end else if (wr_go) begin
      if (address == `OFS_OPTION) begin
        option_reg <= writedata[7:0] & `OPT_MASK;
      end else if (address == `OFS_BITRATE) begin
        bitrate_reg <= writedata[7:0] & `BR_MASK;
      end else if (address == `OFS_MODE) begin
        mode_reg <= writedata[7:0] & 8'h07;
      end else if (address == `OFS_MATCH) begin
        match_reg <= writedata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Fault input only when master, fault enabled and select output off
  assign fault_input = spi_en & master & fault_en & ~sel_out_en;
  assign push_now = rx_valid & rx_ready;

  // Set wins over a write-one clear in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_match_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
    end else if (width_change | ~spi_en) begin
      rx_match_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
    end else begin
      if (push_now & ((rx_word & word_mask) == (match_reg & word_mask))) begin
        rx_match_flag_reg <= 1'b1;
      end else if (wr_go & (address == `OFS_STATUS) & writedata[`ST_MATCH]) begin
        rx_match_flag_reg <= 1'b0;
      end
      if (fault_input & ~ss_n_i) begin
        mode_fault_flag_reg <= 1'b1;
      end else if (wr_go & (address == `OFS_STATUS) & writedata[`ST_FAULT]) begin
        mode_fault_flag_reg <= 1'b0;
      end
    end
  end

  assign match_irq = rx_match_flag_reg & option_reg[`OPT_MIE];

  // Abort strobe tells the shifter to drop its transfer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_pulse <= 1'b0;
    end else begin
      abort_pulse <= width_change;
    end
  end

  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  assign fifo_pop = rd_go & (address == `OFS_RXDATA);

  spi_rx_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .flush(width_change | ~spi_en),
    .in_data(rx_word & word_mask),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(head_word),
    .out_valid(rx_full_flag),
    .out_ready(fifo_pop)
  );

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @* begin
    read_next = 32'h0000_0000;
    if (address == `OFS_OPTION) begin
      read_next[7:0] = option_reg;
    end else if (address == `OFS_BITRATE) begin
      read_next[7:0] = bitrate_reg;
    end else if (address == `OFS_MODE) begin
      read_next[7:0] = mode_reg;
    end else if (address == `OFS_STATUS) begin
      read_next[`ST_FULL] = rx_full_flag;
      read_next[`ST_MATCH] = rx_match_flag_reg;
      read_next[`ST_FAULT] = mode_fault_flag_reg;
    end else if (address == `OFS_MATCH) begin
      read_next[15:0] = match_reg & word_mask;
    end else if (address == `OFS_RXDATA) begin
      read_next[15:0] = rx_full_flag ? head_word : 16'h0000;
    end
  end

  // Data is captured in the wait cycle and stands at the accept edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack_reg) begin
      readdata <= read_next;
    end
  end

  // ----------------------------------------
  // Bit-rate generator
  // ----------------------------------------
  // Clocks freeze in wait only when asked to, saving power
  assign clocks_run = spi_en & master & ~(wait_state & option_reg[`OPT_HALT]);
  assign pre_tick = (pre_cnt_reg == pre_sel);
  assign half_count = 8'h01 << rate_sel;

  // Prescaler counts value plus one bus cycles per tick
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_reg <= 3'h0;
    end else if (~clocks_run | pre_tick) begin
      pre_cnt_reg <= 3'h0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 3'h1;
    end
  end

  // Rate divider toggles the clock every 2^sel ticks: period 2^(sel+1) ticks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_cnt_reg <= 8'h00;
      sck_o <= 1'b0;
      baud_edge <= 1'b0;
    end else if (~clocks_run) begin
      rate_cnt_reg <= 8'h00;
      sck_o <= 1'b0;
      baud_edge <= 1'b0;
    end else if (pre_tick) begin
      if (rate_cnt_reg == half_count - 8'h01) begin
        rate_cnt_reg <= 8'h00;
        sck_o <= ~sck_o;
        baud_edge <= 1'b1;
      end else begin
        rate_cnt_reg <= rate_cnt_reg + 8'h01;
        baud_edge <= 1'b0;
      end
    end else begin
      baud_edge <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin steering
  // ----------------------------------------
  assign shared_mode = single_wire;
  assign sck_oe = spi_en & master;

  // Master drives MOSI, listens on MISO; single-wire master shares MOSI
  assign mosi_o = tx_bit;
  assign mosi_oe = spi_en & master & (~single_wire | drive_en);
  assign miso_o = tx_bit;
  assign miso_oe = spi_en & ~master & (~single_wire | drive_en);
  assign data_in_bit = (master ^ single_wire) ? miso_i : mosi_i;
  assign mosi_gpio_release = ~spi_en | (~master & single_wire);
  assign miso_gpio_release = ~spi_en | (master & single_wire);

  // Select pin: slave input always, master per fault enable and output enable
  assign ss_n_to_slave = (spi_en & ~master) ? ss_n_i : 1'b1;
  assign ss_gpio_release = ~spi_en | (master & ~fault_en);
  assign ss_n_o = ~ss_assert;
  assign ss_n_oe = spi_en & master & fault_en & sel_out_en;

endmodule

// [tb/spi_peer.sv]
// Far-side SPI peer on the block's pins.
// Assumes the bench resolves each pin from the block's enable; the peer drives whenever that is off.
`timescale 1ns/1ns
module spi_peer (
  // Clock and control
  input wire logic clk,
  input wire logic ss_low,
  // Peer drives
  output logic peer_data,
  output logic peer_ss_n
);
  // ----------------
  // Peer behaviour
  // ----------------
  // Data flips every cycle so a stale level can never pass for a live one
  initial peer_data = 1'b0;
  always @(posedge clk) begin
    peer_data <= ~peer_data;
  end
  // Select line has a pull-up: high unless the peer pulls it low
  assign peer_ss_n = ~ss_low;
endmodule

// [tb/spi_ctrl2_and_baud_gen_asserts.sv]
// Port-level checks of the SPI option and bit-rate block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module spi_ctrl2_and_baud_gen_asserts (
  // Clock, reset and bus
  input wire clk,
  input wire rst,
  input wire read,
  input wire write,
  input wire waitrequest,
  // Shifter side
  input wire rx_ready,
  input wire abort_pulse,
  input wire baud_edge,
  input wire shared_mode,
  input wire data_in_bit,
  input wire tx_bit,
  input wire ss_assert,
  input wire match_irq,
  // Pins
  input wire sck_o,
  input wire sck_oe,
  input wire mosi_i,
  input wire mosi_o,
  input wire mosi_oe,
  input wire miso_i,
  input wire miso_o,
  input wire miso_oe,
  input wire ss_n_o,
  input wire ss_n_oe,
  input wire miso_gpio_release
);
  // ----------------
  // Assertions
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  bus_one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered after one wait");
  data_pin_excl_a: assert property (!(mosi_oe && miso_oe))
    else $error("both data pins driven");
  master_two_wire_a: assert property (sck_oe && !shared_mode |->
    mosi_oe && !miso_oe && data_in_bit == miso_i)
    else $error("two-wire master pin use wrong");
  master_one_wire_a: assert property (sck_oe && shared_mode |->
    miso_gpio_release && !miso_oe)
    else $error("single-wire master keeps the unused pin");
  shared_input_a: assert property (sck_oe && shared_mode && !mosi_oe |->
    data_in_bit == mosi_i)
    else $error("undriven shared pin not used as input");
  drive_data_a: assert property (mosi_oe |-> mosi_o == tx_bit)
    else $error("driven data pin does not carry the shifter bit");
  slave_drive_a: assert property (miso_oe |-> miso_o == tx_bit)
    else $error("driven slave pin does not carry the shifter bit");
  sck_toggle_a: assert property (baud_edge |-> sck_o != $past(sck_o))
    else $error("baud strobe without a serial clock toggle");
  abort_clean_a: assert property (abort_pulse |-> !match_irq && rx_ready
    ##1 !abort_pulse)
    else $error("abort leaves state behind or lasts too long");
  select_out_a: assert property (ss_n_oe |-> sck_oe && ss_n_o == !ss_assert)
    else $error("select output driven wrongly");
endmodule
bind spi_ctrl2_and_baud_gen spi_ctrl2_and_baud_gen_asserts i_asserts (
  .clk(clk), .rst(rst), .read(read), .write(write), .waitrequest(waitrequest),
  .rx_ready(rx_ready), .abort_pulse(abort_pulse), .baud_edge(baud_edge),
  .shared_mode(shared_mode), .data_in_bit(data_in_bit), .tx_bit(tx_bit),
  .ss_assert(ss_assert), .match_irq(match_irq), .sck_o(sck_o), .sck_oe(sck_oe),
  .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i),
  .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
  .miso_gpio_release(miso_gpio_release));

// [tb/spi_ctrl2_and_baud_gen_bench.sv]
// Self-checking bench of the SPI option and bit-rate block.
// Assumes the design, peer and checker files are compiled first.
`timescale 1ns/1ns
`include "spi_cfg_map.vh"
module spi_ctrl2_and_baud_gen_bench;
  logic clk, rst, read, write, wait_state, rx_valid, tx_bit, ss_low, seen_abort;
  logic [5:0] address;
  logic [31:0] writedata, rd;
  logic [15:0] rx_word;
  wire [31:0] readdata;
  wire waitrequest, rx_ready, word_16, abort_pulse, baud_edge, shared_mode, data_in_bit;
  wire match_irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
  wire ss_n_to_slave, ss_gpio_release, mosi_gpio_release, miso_gpio_release;
  wire peer_data, peer_ss_n;
  // Each wire level follows the block's enable; the peer drives it otherwise
  wire mosi = mosi_oe ? mosi_o : peer_data;
  wire miso = miso_oe ? miso_o : peer_data;
  wire ss_n = ss_n_oe ? ss_n_o : peer_ss_n;
  int err_count, checked, cyc, n;
  // Baud settings under test: prescale in 6:4, rate in 2:0
  logic [7:0] n_tab [4] = '{8'h00, 8'h70, 8'h23, 8'h77};
  spi_ctrl2_and_baud_gen i_spi_ctrl2_and_baud_gen (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .wait_state(wait_state),
    .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready), .word_16(word_16),
    .abort_pulse(abort_pulse), .baud_edge(baud_edge), .shared_mode(shared_mode),
    .data_in_bit(data_in_bit), .tx_bit(tx_bit), .ss_assert(tx_bit),
    .match_irq(match_irq), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso), .miso_o(miso_o),
    .miso_oe(miso_oe), .ss_n_i(ss_n), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
    .ss_n_to_slave(ss_n_to_slave), .ss_gpio_release(ss_gpio_release),
    .mosi_gpio_release(mosi_gpio_release), .miso_gpio_release(miso_gpio_release));
  spi_peer i_spi_peer (.clk(clk), .ss_low(ss_low), .peer_data(peer_data),
    .peer_ss_n(peer_ss_n));
  // ----------------
  // Clock, timeout, abort watch
  // ----------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Longest test is the slowest baud setting, a few thousand cycles
  always @(posedge clk) begin
    cyc++;
    tx_bit <= ~tx_bit;
    if (abort_pulse === 1'b1) seen_abort <= 1'b1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~w;
    write <= w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 0);
    chk(rd, e);
  endtask
  task automatic push(input logic [15:0] w);
    @(posedge clk);
    rx_word <= w;
    rx_valid <= 1'b1;
    do @(posedge clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
  endtask
  // Counts baud strobes over 20 cycles, after the last write has settled
  task automatic edges;
    n = 0;
    @(posedge clk);
    repeat (20) begin
      @(negedge clk);
      if (baud_edge === 1'b1) n++;
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------
  // Test sequence
  // ----------------
  initial begin
    {rst, read, write, wait_state, rx_valid, tx_bit, ss_low, seen_abort} = 8'h80;
    {address, writedata, rx_word} = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(1, `OFS_OPTION, 32'hff);
    rchk(`OFS_OPTION, 32'hdb);
    bus(1, `OFS_BITRATE, 32'hff);
    rchk(`OFS_BITRATE, 32'h77);
    rchk(6'h3c, 0);
    bus(1, `OFS_OPTION, 0);
    bus(1, `OFS_MODE, 3);
    // Toggle spacing is prescale plus one times a power of two, ascending order
    foreach (n_tab[i]) begin
      bus(1, `OFS_BITRATE, n_tab[i][7:0]);
      repeat (2) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (baud_edge !== 1'b1);
      end
      chk(n, (n_tab[i][6:4] + 1) << n_tab[i][2:0]);
    end
    bus(1, `OFS_BITRATE, 0);
    wait_state <= 1'b1;
    bus(1, `OFS_OPTION, 32'h02);
    edges();
    chk(n, 0);
    bus(1, `OFS_OPTION, 0);
    edges();
    chk(n, 20);
    wait_state <= 1'b0;
    // Master pin use: drive-enable only counts in single-wire mode
    for (int i = 0; i < 4; i++) begin
      bus(1, `OFS_OPTION, {i[1], 2'b00, i[0]});
      @(negedge clk);
      chk({mosi_oe, miso_oe, miso_gpio_release, shared_mode},
        {i[1] | ~i[0], 1'b0, i[0], i[0]});
    end
    bus(1, `OFS_MODE, 1);
    for (int i = 0; i < 4; i++) begin
      bus(1, `OFS_OPTION, {i[1], 2'b00, i[0]});
      @(negedge clk);
      chk({mosi_gpio_release, miso_oe, data_in_bit, ss_n_to_slave, ss_gpio_release},
        {i[0], ~i[0] | i[1], i[0] ? miso : mosi, ss_n, 1'b0});
    end
    bus(1, `OFS_OPTION, 32'h10);
    ss_low <= 1'b1;
    @(negedge clk);
    chk({ss_n_to_slave, ss_n_oe}, 2'b00);
    bus(1, `OFS_OPTION, 0);
    bus(1, `OFS_MODE, 3);
    @(negedge clk);
    chk({ss_gpio_release, ss_n_oe}, 2'b10);
    bus(1, `OFS_OPTION, 32'h10);
    rchk(`OFS_STATUS, 32'h10);
    bus(1, `OFS_MODE, 7);
    @(negedge clk);
    chk({ss_gpio_release, ss_n_oe}, 2'b01);
    ss_low <= 1'b0;
    bus(1, `OFS_MODE, 3);
    bus(1, `OFS_STATUS, 32'h10);
    bus(1, `OFS_MATCH, 32'h00a5);
    bus(1, `OFS_OPTION, 32'h80);
    push(16'h12a5);
    @(negedge clk);
    chk(match_irq, 1);
    rchk(`OFS_STATUS, 32'hc0);
    bus(1, `OFS_STATUS, 32'h40);
    bus(1, `OFS_OPTION, 0);
    push(16'h34a5);
    @(negedge clk);
    chk(match_irq, 0);
    rchk(`OFS_STATUS, 32'hc0);
    for (int k = 2; k < 32; k++) push(k[15:0]);
    // Thirty-third word must wait while the buffer is full
    @(posedge clk);
    rx_valid <= 1'b1;
    repeat (4) @(posedge clk);
    chk(rx_ready, 0);
    rx_valid <= 1'b0;
    rchk(`OFS_RXDATA, 32'ha5);
    rchk(`OFS_RXDATA, 32'ha5);
    for (int k = 2; k < 32; k++) rchk(`OFS_RXDATA, k);
    rchk(`OFS_STATUS, 32'h40);
    bus(1, `OFS_OPTION, 32'h40);
    // Abort strobe follows the write by one edge and is caught one edge later
    repeat (3) @(negedge clk);
    chk({seen_abort, word_16}, 2'b11);
    rchk(`OFS_STATUS, 0);
    push(16'h12a5);
    rchk(`OFS_STATUS, 32'h80);
    rchk(`OFS_RXDATA, 32'h12a5);
    close_out();
  end
endmodule
